// File: hdl/hlpt_pkg.sv
// Constants and types for the hardware limit period timer
package hlpt_pkg;

    // Register byte offsets
    localparam logic [7:0] OFS_CONTROL = 8'h00;
    localparam logic [7:0] OFS_LIMIT   = 8'h04;
    localparam logic [7:0] OFS_CLKSEL  = 8'h08;
    localparam logic [7:0] OFS_RSTSEL  = 8'h0c;
    localparam logic [7:0] OFS_PERIOD  = 8'h10;
    localparam logic [7:0] OFS_COUNT   = 8'h14;
    localparam logic [7:0] OFS_STATUS  = 8'h18;

    // Field positions
    localparam int ON_BIT      = 0;
    localparam int STAT_RUN    = 0;
    localparam int STAT_EN     = 1;

    // Values after reset
    localparam logic [4:0] MODE_RST   = 5'h00;
    localparam logic [2:0] CLKSEL_RST = 3'h0;
    localparam logic [2:0] RSTSEL_RST = 3'h0;
    localparam logic [7:0] PERIOD_RST = 8'hff;

    // Bus encodings
    localparam logic [2:0] HSIZE_WORD = 3'h2;

    // Timer clock sources
    localparam logic [2:0] CK_SYS    = 3'h0;
    localparam logic [2:0] CK_DIV4   = 3'h1;
    localparam logic [2:0] CK_LF     = 3'h2;
    localparam logic [2:0] CK_MF     = 3'h3;
    localparam logic [2:0] CK_HF     = 3'h4;
    localparam logic [2:0] CK_OTHER  = 3'h5;
    localparam logic [2:0] CK_PIN    = 3'h6;
    localparam logic [1:0] DIV4_LAST = 2'h3;

    // Operating modes
    typedef enum logic [4:0] {
        M_SW_GATE     = 5'b00000,
        M_ROLL_LOW    = 5'b00001,
        M_ROLL_HIGH   = 5'b00010,
        M_ROLL_EITHER = 5'b00011,
        M_ROLL_FALL   = 5'b00100,
        M_ROLL_RISE   = 5'b00101,
        M_GATE_HIGH   = 5'b00110,
        M_GATE_LOW    = 5'b00111,
        M_OS_SW       = 5'b01000,
        M_OS_RISE     = 5'b01001,
        M_OS_FALL     = 5'b01010,
        M_OS_EITHER   = 5'b01011,
        M_OS_RISE_RST = 5'b01100,
        M_OS_FALL_RST = 5'b01101,
        M_OS_LVL_HIGH = 5'b01110,
        M_OS_LVL_LOW  = 5'b01111,
        M_MONO_RISE   = 5'b10001,
        M_MONO_FALL   = 5'b10010,
        M_MONO_EITHER = 5'b10011,
        M_OS_RISE_LOW = 5'b10110,
        M_OS_FALL_HI  = 5'b10111
    } hlpt_mode_t;

endpackage

// File: hdl/hlpt_timer.sv
// Hardware limit period timer with AHB-Lite register slave
//
// Summary of operation
// R1 - Software gate: count while enabled, clear on period match, stop when off.
// R2 - Active-high gate: count only with input high and enable set.
// R3 - Active-low gate: count only with input low and enable set.
// R4 - Rollover: increment per timer clock, freeze when off, resume from value.
// R5 - Rollover: on period match return to zero next clock and continue.
// R6 - Edge rollover: enable starts; selected edge clears counter and restarts.
// R7 - Edge rollover codes: 00101 rising, 00100 falling, 00011 either edge.
// R8 - Level rollover: held cleared while input high (00010) or low (00001).
// R9 - With enable off, no counting and external edges are ignored.
// R10 - Start and stop follow the enable within two timer clocks.
// R11 - Software changes the enable at times unrelated to the timer clock.
// R12 - Every limit mode lets the selected input clear and restart counting; code does not in modes 00000, 00110, 00111, 01000-01011, 10001-10011.
// R13 - Edge-start one-shot begins counting on the selected edge once enabled.
// R14 - Edge one-shot with limit: first edge starts, later edges clear.
// R15 - Edge start with level reset: rise with low reset, fall with high.
// R16 - Level one-shot counts at start level; opposite level resets counter.
// R17 - Monostable: qualifying edge starts a run, period match ends it.
// R18 - Timer clock chosen among system, divided by four, oscillators, pins.
// R19 - External reset input chosen from a pin or on-chip sources.
// R20 - Period match raises the missed-event interrupt request.
// R21 - One-shot modes clear the enable themselves at rollover.
// R22 - Edge limit one-shot codes: 01100 rising, 01101 falling.
// R23 - Level limit one-shot codes: 01110 high start, 01111 low start.
// R24 - Monostable stops without clearing enable; codes 10001, 10010, 10011.
// R25 - Enable and external input are synchronised before use.
// R26 - Period match is count equal to period on each active timer clock.
//
// Our own choices: the AHB-Lite interface to the registers and the address map.
`timescale 1ns/10ps
`default_nettype none

module hlpt_timer #(
    parameter int CW = 8
) (
    input  wire logic          clk_sys,
    input  wire logic          rst,
    input  wire logic          hsel,
    input  wire logic [31:0]   haddr,
    input  wire logic [1:0]    htrans,
    input  wire logic          hwrite,
    input  wire logic [2:0]    hsize,
    input  wire logic [31:0]   hwdata,
    input  wire logic          hready,
    output logic      [31:0]   hrdata,
    output logic               hreadyout,
    output logic               hresp,
    input  wire logic          osc_lf_in,
    input  wire logic          osc_mf_in,
    input  wire logic          osc_hf_in,
    input  wire logic          other_timer_in,
    input  wire logic          timer_pin_in,
    input  wire logic          reset_pin_in,
    input  wire logic          waveform_src_in,
    input  wire logic          zero_cross_src_in,
    input  wire logic          capture_compare_src_in,
    input  wire logic          other_timer_a_src_in,
    input  wire logic          other_timer_b_src_in,
    input  wire logic          comparator_src_in,
    output logic               period_match_irq,
    output logic      [CW-1:0] count_value
);

    localparam int NA = 12;

    // Bus state
    logic          wr_pend_reg;
    logic          rd_pend_reg;
    logic          rd_ready_reg;
    logic [7:0]    addr_reg;
    logic          word_reg;
    logic [31:0]   hrdata_reg;

    // Configuration
    logic          on_reg;
    logic [4:0]    mode_reg;
    logic [2:0]    clksel_reg;
    logic [2:0]    rstsel_reg;
    logic [CW-1:0] period_reg;
    logic [CW-1:0] count_reg;
    logic [CW-1:0] count_next;

    // Timer side
    logic [NA-1:0] async_s1_reg;
    logic [NA-1:0] async_s2_reg;
    logic [4:0]    ck_prev_reg;
    logic [1:0]    div_reg;
    logic          on_s1_reg;
    logic          on_s2_reg;
    logic          inp_prev_reg;
    logic          inp_reg;
    logic          run_reg;
    logic          run_next;
    logic          irq_reg;

    // Asynchronous inputs: clock sources low, reset sources high
    wire [NA-1:0] async_in = {comparator_src_in, other_timer_b_src_in,
                              other_timer_a_src_in, capture_compare_src_in,
                              zero_cross_src_in, waveform_src_in,
                              reset_pin_in, timer_pin_in, other_timer_in,
                              osc_hf_in, osc_mf_in, osc_lf_in};

    // R25 two-stage synchronisers
    genvar gi;
    generate
        for (gi = 0; gi < NA; gi++) begin : g_sync
            always_ff @(posedge clk_sys) begin
                if (rst) begin
                    async_s1_reg[gi] <= 1'b0;
                    async_s2_reg[gi] <= 1'b0;
                end else begin
                    async_s1_reg[gi] <= async_in[gi];
                    async_s2_reg[gi] <= async_s1_reg[gi];
                end
            end
        end
    endgenerate

    // Bus decode
    wire take     = hsel & htrans[1] & hready;
    wire wr_ok    = wr_pend_reg & word_reg;
    wire wr_ctrl  = wr_ok & (addr_reg == hlpt_pkg::OFS_CONTROL);
    wire wr_limit = wr_ok & (addr_reg == hlpt_pkg::OFS_LIMIT);
    wire wr_ck    = wr_ok & (addr_reg == hlpt_pkg::OFS_CLKSEL);
    wire wr_rs    = wr_ok & (addr_reg == hlpt_pkg::OFS_RSTSEL);
    wire wr_per   = wr_ok & (addr_reg == hlpt_pkg::OFS_PERIOD);
    wire wr_count = wr_ok & (addr_reg == hlpt_pkg::OFS_COUNT);

    wire [31:0] rd_mux =
        (addr_reg == hlpt_pkg::OFS_CONTROL) ? {31'h0, on_reg} :
        (addr_reg == hlpt_pkg::OFS_LIMIT)   ? {27'h0, mode_reg} :
        (addr_reg == hlpt_pkg::OFS_CLKSEL)  ? {29'h0, clksel_reg} :
        (addr_reg == hlpt_pkg::OFS_RSTSEL)  ? {29'h0, rstsel_reg} :
        (addr_reg == hlpt_pkg::OFS_PERIOD)  ? 32'(period_reg) :
        (addr_reg == hlpt_pkg::OFS_COUNT)   ? 32'(count_reg) :
        (addr_reg == hlpt_pkg::OFS_STATUS)  ? {30'h0, on_s2_reg, run_reg} :
        32'h0;

    assign hreadyout = ~(rd_pend_reg & ~rd_ready_reg);
    assign hresp     = 1'b0;
    assign hrdata    = hrdata_reg;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            wr_pend_reg  <= 1'b0;
            rd_pend_reg  <= 1'b0;
            rd_ready_reg <= 1'b0;
            addr_reg     <= 8'h00;
            word_reg     <= 1'b0;
        end else if (hready) begin
            wr_pend_reg  <= take & hwrite;
            rd_pend_reg  <= take & ~hwrite;
            rd_ready_reg <= 1'b0;
            addr_reg     <= {haddr[7:2], 2'b00};
            word_reg     <= (hsize == hlpt_pkg::HSIZE_WORD) & (haddr[1:0] == 2'b00);
        end else begin
            wr_pend_reg  <= 1'b0;
            rd_ready_reg <= rd_pend_reg;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            hrdata_reg <= 32'h0;
        end else if (rd_pend_reg & ~rd_ready_reg) begin
            hrdata_reg <= rd_mux;
        end
    end

    // R18 timer clock selection as a tick
    wire [4:0] ck_sync = async_s2_reg[4:0];
    wire [4:0] ck_rise = ck_sync & ~ck_prev_reg;
    wire tick =
        (clksel_reg == hlpt_pkg::CK_SYS)   ? 1'b1 :
        (clksel_reg == hlpt_pkg::CK_DIV4)  ? (div_reg == hlpt_pkg::DIV4_LAST) :
        (clksel_reg == hlpt_pkg::CK_LF)    ? ck_rise[0] :
        (clksel_reg == hlpt_pkg::CK_MF)    ? ck_rise[1] :
        (clksel_reg == hlpt_pkg::CK_HF)    ? ck_rise[2] :
        (clksel_reg == hlpt_pkg::CK_OTHER) ? ck_rise[3] :
        (clksel_reg == hlpt_pkg::CK_PIN)   ? ck_rise[4] :
        1'b0;

    // R19 external reset source selection
    wire [6:0] rs_sync = async_s2_reg[NA-1:5];
    wire inp_sel = (rstsel_reg < 3'h7) ? rs_sync[rstsel_reg] : 1'b0;

    // Mode decode
    hlpt_pkg::hlpt_mode_t mode;
    assign mode = hlpt_pkg::hlpt_mode_t'(mode_reg);
    wire en       = on_s2_reg;
    wire inp      = inp_reg;
    wire rise     = inp & ~inp_prev_reg;
    wire fall     = ~inp & inp_prev_reg;
    wire edge_any = rise | fall;
    // R22 edge limit one-shot codes
    wire es_os    = (mode == hlpt_pkg::M_OS_RISE_RST) |
                    (mode == hlpt_pkg::M_OS_FALL_RST);
    // R23 level limit one-shot codes
    wire lvl_os   = (mode == hlpt_pkg::M_OS_LVL_HIGH) |
                    (mode == hlpt_pkg::M_OS_LVL_LOW);
    // R24 monostable codes
    wire is_mono  = (mode == hlpt_pkg::M_MONO_RISE) |
                    (mode == hlpt_pkg::M_MONO_FALL) |
                    (mode == hlpt_pkg::M_MONO_EITHER);
    wire is_os    = (mode_reg[4:3] == 2'b01) |
                    (mode == hlpt_pkg::M_OS_RISE_LOW) |
                    (mode == hlpt_pkg::M_OS_FALL_HI);
    wire latched  = (is_os & ~lvl_os) | is_mono;

    // R13 start trigger for edge-started modes and the software-started one-shot
    wire start_trig =
        (mode == hlpt_pkg::M_OS_SW) |
        (rise & ((mode == hlpt_pkg::M_OS_RISE) | (mode == hlpt_pkg::M_OS_RISE_RST) |
                 (mode == hlpt_pkg::M_OS_RISE_LOW) | (mode == hlpt_pkg::M_MONO_RISE))) |
        (fall & ((mode == hlpt_pkg::M_OS_FALL) | (mode == hlpt_pkg::M_OS_FALL_RST) |
                 (mode == hlpt_pkg::M_OS_FALL_HI) | (mode == hlpt_pkg::M_MONO_FALL))) |
        (edge_any & ((mode == hlpt_pkg::M_OS_EITHER) |
                     (mode == hlpt_pkg::M_MONO_EITHER)));

    // R6 R7 rollover reset edge selection
    wire roll_edge = (rise & (mode == hlpt_pkg::M_ROLL_RISE)) |
                     (fall & (mode == hlpt_pkg::M_ROLL_FALL)) |
                     (edge_any & (mode == hlpt_pkg::M_ROLL_EITHER));

    // R8 R15 level reset conditions
    wire lvl_rst = (inp & (mode == hlpt_pkg::M_ROLL_HIGH)) |
                   (~inp & (mode == hlpt_pkg::M_ROLL_LOW)) |
                   (~inp & (mode == hlpt_pkg::M_OS_RISE_LOW)) |
                   (inp & (mode == hlpt_pkg::M_OS_FALL_HI));

    // R2 R3 R16 gating levels
    wire gate_ok =
        ((mode == hlpt_pkg::M_GATE_HIGH) | (mode == hlpt_pkg::M_OS_LVL_HIGH)) ? inp :
        ((mode == hlpt_pkg::M_GATE_LOW) | (mode == hlpt_pkg::M_OS_LVL_LOW)) ? ~inp :
        1'b1;

    // R1 R4 R9 counting only while enabled
    wire active = en & gate_ok & (~latched | run_reg | start_trig);

    // R26 period match while counting
    wire match_evt = active & (count_reg == period_reg);

    // R12 R14 external clear and restart
    wire ext_clr = en & (roll_edge | lvl_rst | (es_os & run_reg & start_trig) |
                         (lvl_os & ~gate_ok));

    wire clr = match_evt | ext_clr;
    wire hw_off = tick & match_evt & is_os;

    // R5 clear on match, else count
    assign count_next = clr ? '0 : active ? count_reg + 1'b1 : count_reg;

    // R17 monostable and one-shot run latch
    assign run_next = en & latched & ~match_evt & (run_reg | start_trig);

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            on_reg     <= 1'b0;
            mode_reg   <= hlpt_pkg::MODE_RST;
            clksel_reg <= hlpt_pkg::CLKSEL_RST;
            rstsel_reg <= hlpt_pkg::RSTSEL_RST;
            period_reg <= CW'(hlpt_pkg::PERIOD_RST);
        end else begin
            // R21 software write wins over hardware clear
            if (wr_ctrl) begin
                on_reg <= hwdata[hlpt_pkg::ON_BIT];
            end else if (hw_off) begin
                on_reg <= 1'b0;
            end
            if (wr_limit) begin
                mode_reg <= hwdata[4:0];
            end
            if (wr_ck) begin
                clksel_reg <= hwdata[2:0];
            end
            if (wr_rs) begin
                rstsel_reg <= hwdata[2:0];
            end
            if (wr_per) begin
                period_reg <= hwdata[CW-1:0];
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ck_prev_reg <= 5'h00;
            div_reg     <= 2'h0;
            inp_reg     <= 1'b0;
        end else begin
            ck_prev_reg <= ck_sync;
            div_reg     <= div_reg + 2'h1;
            inp_reg     <= inp_sel;
        end
    end

    // R10 R11 enable passes two timer clocks
    always_ff @(posedge clk_sys) begin
        if (rst | hw_off) begin
            on_s1_reg <= 1'b0;
            on_s2_reg <= 1'b0;
        end else if (tick) begin
            on_s1_reg <= on_reg;
            on_s2_reg <= on_s1_reg;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            count_reg    <= '0;
            run_reg      <= 1'b0;
            inp_prev_reg <= 1'b0;
            irq_reg      <= 1'b0;
        end else begin
            // R20 missed-event request on match
            irq_reg <= tick & match_evt;
            if (wr_count) begin
                count_reg <= hwdata[CW-1:0];
            end else if (tick) begin
                count_reg <= count_next;
            end
            if (tick) begin
                run_reg      <= run_next;
                inp_prev_reg <= inp;
            end
        end
    end

    assign period_match_irq = irq_reg;
    assign count_value      = count_reg;

    a_match_clear: assert property (  // R5
        @(posedge clk_sys) disable iff (rst)
        (tick && match_evt && !wr_count) |=> (count_reg == '0))
        else $error("count not cleared after match");

    a_off_freeze: assert property (  // R9
        @(posedge clk_sys) disable iff (rst)
        (tick && !en && !wr_count) |=> $stable(count_reg))
        else $error("count moved while disabled");

    a_gate_high: assert property (  // R2
        @(posedge clk_sys) disable iff (rst)
        (tick && en && !inp && mode == hlpt_pkg::M_GATE_HIGH && !wr_count)
        |=> $stable(count_reg))
        else $error("gate high counted with input low");

    a_edge_reset: assert property (  // R6
        @(posedge clk_sys) disable iff (rst)
        (tick && en && rise && mode == hlpt_pkg::M_ROLL_RISE && !wr_count)
        |=> (count_reg == '0))
        else $error("rising edge did not clear count");

    a_level_hold: assert property (  // R8
        @(posedge clk_sys) disable iff (rst)
        (tick && en && inp && mode == hlpt_pkg::M_ROLL_HIGH && !wr_count)
        |=> (count_reg == '0))
        else $error("high level did not hold count clear");

    a_oneshot_off: assert property (  // R21
        @(posedge clk_sys) disable iff (rst)
        (tick && match_evt && is_os && !wr_ctrl) |=> (!on_reg && !en))
        else $error("one-shot left enable set");

    a_mono_stop: assert property (  // R24
        @(posedge clk_sys) disable iff (rst)
        (tick && match_evt && is_mono && on_reg && !wr_ctrl)
        |=> (on_reg && !run_reg))
        else $error("monostable run did not end correctly");

    a_enable_lag: assert property (  // R10
        @(posedge clk_sys) disable iff (rst)
        ($rose(on_reg) && clksel_reg == hlpt_pkg::CK_SYS)
        ##1 (on_reg && clksel_reg == hlpt_pkg::CK_SYS)
        |=> (en || !on_reg))
        else $error("enable not seen within two timer clocks");

    a_irq_match: assert property (  // R20
        @(posedge clk_sys) disable iff (rst)
        (tick && match_evt) |=> period_match_irq ##1 !period_match_irq
        || (tick && match_evt))
        else $error("match request malformed");

endmodule

`default_nettype wire

// File: tb/hlpt_ext_src.sv
// Behavioural model of the external limit signal source
`timescale 1ns/10ps
`default_nettype none

module hlpt_ext_src (
    input  wire logic clk_sys,
    input  wire logic rst,
    input  wire logic level_req,
    input  wire logic slow,
    output logic      sig_out
);
    logic [3:0] dly_reg;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            dly_reg <= 4'h0;
        end else begin
            dly_reg <= {dly_reg[2:0], level_req};
        end
    end

    assign sig_out = slow ? dly_reg[3] : dly_reg[0];
endmodule

`default_nettype wire

// File: tb/test_hardware_limit_period_timer.sv
// Self-checking bench for the hardware limit period timer
`timescale 1ns/10ps
`default_nettype none

module test_hardware_limit_period_timer;
    localparam logic [6:0]  EDGE_TAB [5] = '{7'h16, 7'h11, 7'h0f, 7'h0b, 7'h07};
    localparam logic [5:0]  GATE_TAB [2] = '{6'h0d, 6'h0e};
    localparam logic [5:0]  SHOT_TAB [3] = '{6'h18, 6'h23, 6'h12};
    localparam logic [23:0] CLK_TAB  [4] = '{24'h01121c, 24'h060206,
                                             24'h020206, 24'h005078};
    logic        clk_sys;
    logic        rst;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic        period_match_irq;
    logic [7:0]  count_value;
    logic [4:0]  ck_src;
    logic [2:0]  ck_cnt;
    logic        ext_level;
    logic        ext_slow;
    logic        ext_sig;
    logic [2:0]  route_sel;
    logic [6:0]  rst_src;
    logic [31:0] rd;
    logic [31:0] keep;
    int          err_count;
    int          checked;
    int          i;
    int          n;

    assign rst_src = {6'h00, ext_sig} << route_sel;

    hlpt_timer hlpt_timer_i (
        .clk_sys(clk_sys), .rst(rst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .osc_lf_in(ck_src[0]), .osc_mf_in(ck_src[1]),
        .osc_hf_in(ck_src[2]), .other_timer_in(ck_src[3]),
        .timer_pin_in(ck_src[4]), .reset_pin_in(rst_src[0]),
        .waveform_src_in(rst_src[1]), .zero_cross_src_in(rst_src[2]),
        .capture_compare_src_in(rst_src[3]),
        .other_timer_a_src_in(rst_src[4]), .other_timer_b_src_in(rst_src[5]),
        .comparator_src_in(rst_src[6]), .period_match_irq(period_match_irq),
        .count_value(count_value)
    );

    hlpt_ext_src hlpt_ext_src_i (
        .clk_sys(clk_sys), .rst(rst), .level_req(ext_level),
        .slow(ext_slow), .sig_out(ext_sig)
    );

    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end

    always @(posedge clk_sys) begin
        ck_cnt <= ck_cnt + 3'h1;
        if (ck_cnt == 3'h7) begin
            ck_src <= ~ck_src;
        end
    end

    task automatic tally_and_finish;
        $display("Checks %0d, mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wait_flag(input logic irq, input int lim,
                             output logic [31:0] d, output int c);
        logic r;
        r = 1'b0;
        c = 0;
        while (!r) begin
            @(negedge clk_sys);
            r = irq ? (period_match_irq === 1'b1) : (hreadyout === 1'b1);
            d = hrdata;
            @(posedge clk_sys);
            c++;
            if (!r && c > lim) begin
                err_count++;
                tally_and_finish;
            end
        end
    endtask

    task automatic ahb_xfer(input logic wr, input logic [7:0] a,
                            input logic [31:0] wd);
        int c;
        hsel   <= 1'b1;
        haddr  <= {24'h000000, a};
        htrans <= 2'h2;
        hwrite <= wr;
        hsize  <= hlpt_pkg::HSIZE_WORD;
        wait_flag(1'b0, 50, rd, c);
        htrans <= 2'h0;
        hwdata <= wd;
        wait_flag(1'b0, 50, rd, c);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        ahb_xfer(1'b1, a, d);
    endtask

    task automatic rdr(input logic [7:0] a);
        ahb_xfer(1'b0, a, 32'h0);
    endtask

    task automatic cycles(input int k);
        repeat (k) @(posedge clk_sys);
    endtask

    initial begin
        rst = 1'b1;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h0;
        hwdata = 32'h0;
        ck_src = 5'h00;
        ck_cnt = 3'h0;
        ext_level = 1'b0;
        ext_slow = 1'b0;
        route_sel = 3'h0;
        err_count = 0;
        checked = 0;
        repeat (20) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        // Reset values, then an unmapped place that drops writes
        wr(8'h1c, 32'h5a5a5a5a);
        for (i = 0; i < 8; i++) begin
            rdr(8'(i * 4));
            check_val(rd, (i == 4) ? 32'h000000ff : 32'h0);
            check_val({31'h0, hresp}, 32'h0);
        end
        wr(hlpt_pkg::OFS_PERIOD, 32'h3);
        wr(hlpt_pkg::OFS_CONTROL, 32'h1);
        wait_flag(1'b1, 40, rd, n);
        wait_flag(1'b1, 40, rd, n);
        check_val(32'(n), 32'h4);
        wr(hlpt_pkg::OFS_CONTROL, 32'h0);
        cycles(4);
        rdr(hlpt_pkg::OFS_COUNT);
        keep = rd;
        cycles(8);
        rdr(hlpt_pkg::OFS_COUNT);
        check_val(rd, keep);
        check_val({24'h0, count_value}, keep);
        wr(hlpt_pkg::OFS_PERIOD, 32'hff);
        wr(hlpt_pkg::OFS_RSTSEL, 32'h3);
        route_sel <= 3'h3;
        wr(hlpt_pkg::OFS_LIMIT, 32'h05);
        wr(hlpt_pkg::OFS_COUNT, 32'h80);
        ext_level <= 1'b1;
        cycles(10);
        rdr(hlpt_pkg::OFS_COUNT);
        check_val(rd, 32'h80);
        ext_level <= 1'b0;
        cycles(10);
        wr(hlpt_pkg::OFS_CONTROL, 32'h1);
        cycles(6);
        rdr(hlpt_pkg::OFS_COUNT);
        check_val({31'h0, rd > 32'h80 && rd < 32'h90}, 32'h1);
        for (i = 0; i < 5; i++) begin
            wr(hlpt_pkg::OFS_LIMIT, {27'h0, EDGE_TAB[i][6:2]});
            wr(hlpt_pkg::OFS_COUNT, 32'h80);
            ext_level <= 1'b1;
            cycles(8);
            rdr(hlpt_pkg::OFS_COUNT);
            check_val({31'h0, rd < 32'h40}, {31'h0, EDGE_TAB[i][1]});
            wr(hlpt_pkg::OFS_COUNT, 32'h80);
            ext_level <= 1'b0;
            cycles(8);
            rdr(hlpt_pkg::OFS_COUNT);
            check_val({31'h0, rd < 32'h40}, {31'h0, EDGE_TAB[i][0]});
        end
        ext_slow <= 1'b1;
        route_sel <= 3'h6;
        wr(hlpt_pkg::OFS_RSTSEL, 32'h6);
        for (i = 0; i < 2; i++) begin
            wr(hlpt_pkg::OFS_LIMIT, {27'h0, GATE_TAB[i][5:1]});
            ext_level <= ~GATE_TAB[i][0];
            cycles(10);
            wr(hlpt_pkg::OFS_COUNT, 32'h20);
            cycles(10);
            rdr(hlpt_pkg::OFS_COUNT);
            check_val(rd, 32'h20);
            ext_level <= GATE_TAB[i][0];
            cycles(12);
            rdr(hlpt_pkg::OFS_COUNT);
            check_val({31'h0, rd > 32'h20}, 32'h1);
        end
        ext_slow <= 1'b0;
        route_sel <= 3'h0;
        wr(hlpt_pkg::OFS_RSTSEL, 32'h0);
        wr(hlpt_pkg::OFS_PERIOD, 32'h10);
        for (i = 0; i < 3; i++) begin
            wr(hlpt_pkg::OFS_CONTROL, 32'h0);
            wr(hlpt_pkg::OFS_LIMIT, {27'h0, SHOT_TAB[i][5:1]});
            ext_level <= 1'b0;
            wr(hlpt_pkg::OFS_COUNT, 32'h0);
            wr(hlpt_pkg::OFS_CONTROL, 32'h1);
            cycles(8);
            rdr(hlpt_pkg::OFS_COUNT);
            check_val(rd, 32'h0);
            ext_level <= 1'b1;
            wait_flag(1'b1, 100, keep, n);
            cycles(4);
            rdr(hlpt_pkg::OFS_CONTROL);
            check_val(rd, {31'h0, SHOT_TAB[i][0]});
            rdr(hlpt_pkg::OFS_COUNT);
            check_val(rd, 32'h0);
            rdr(hlpt_pkg::OFS_STATUS);
            check_val(rd, {30'h0, SHOT_TAB[i][0], 1'b0});
        end
        wr(hlpt_pkg::OFS_LIMIT, 32'h0);
        wr(hlpt_pkg::OFS_PERIOD, 32'hff);
        for (i = 0; i < 4; i++) begin
            wr(hlpt_pkg::OFS_CONTROL, 32'h0);
            // Let the old timer clock carry the stop through first
            cycles(40);
            wr(hlpt_pkg::OFS_CLKSEL, {24'h0, CLK_TAB[i][23:16]});
            wr(hlpt_pkg::OFS_COUNT, 32'h0);
            wr(hlpt_pkg::OFS_CONTROL, 32'h1);
            cycles(100);
            rdr(hlpt_pkg::OFS_COUNT);
            check_val({31'h0, rd >= {24'h0, CLK_TAB[i][15:8]}
                       && rd <= {24'h0, CLK_TAB[i][7:0]}}, 32'h1);
        end
        tally_and_finish;
    end
endmodule

`default_nettype wire
